/* wkup_params.svh */
// Function
// - Wake-up inputs are gathered and raised as requests to the interrupt controller.
// - Thirty-two wake-up channels, carrying internal sources or external pin inputs.
// - Channels accept external pin inputs and internal module inputs alike.
// - Each channel independently triggers on its rising or falling edge.
// - A disabled channel bypasses the sense latch straight to the interrupt controller.
// - Block decodes at base 1B00h; edge-mode registers sit at offsets 00h-03h; the code word-aligns them at byte offsets 00h, 04h, 08h, 0Ch.
// - Edge-sense registers sit at offsets 04h-07h; the code places them at byte offsets 10h, 14h, 18h, 1Ch.
// - Wake-enable registers sit at offsets 08h-0Bh; the code places them at byte offsets 20h, 24h, 28h, 2Ch.
// - First edge-mode register: eight read/write bits, reset 0; 0 rising, 1 falling.
// - Wake outputs of inputs A and D are OR-ed onto interrupt channel five.
// - Sense bits set only by hardware; writing 1 clears, writing 0 does nothing.
// - Enabled channel trigger makes a request; disabled trigger is dropped, not pending.
`ifndef WKUP_PARAMS_SVH
`define WKUP_PARAMS_SVH

`define WKUP_CHANNELS 32
`define WKUP_GROUPS 4
`define WKUP_GRP_W 8
`define WKUP_BASE_ADDR 16'h1B00

`define WKUP_IDX_MODE1 4'h0
`define WKUP_IDX_MODE2 4'h1
`define WKUP_IDX_MODE3 4'h2
`define WKUP_IDX_MODE4 4'h3
`define WKUP_IDX_SENSE1 4'h4
`define WKUP_IDX_SENSE2 4'h5
`define WKUP_IDX_SENSE3 4'h6
`define WKUP_IDX_SENSE4 4'h7
`define WKUP_IDX_EN1 4'h8
`define WKUP_IDX_EN2 4'h9
`define WKUP_IDX_EN3 4'hA
`define WKUP_IDX_EN4 4'hB
`define WKUP_IDX_EVT_STAT 4'hC
`define WKUP_IDX_EVT_MASK 4'hD

`define WKUP_RST_MODE 8'h00
`define WKUP_RST_SENSE 8'h00
`define WKUP_RST_EN 8'h00
`define WKUP_RST_EVT 2'h0

`define WKUP_EVT_LATCH 0
`define WKUP_EVT_DROP 1

`define WKUP_CH_A 5'h00
`define WKUP_CH_D 5'h03

`endif

/* wkup_pkg.sv */
`include "wkup_params.svh"
package wkup_pkg;

    typedef logic [`WKUP_CHANNELS-1:0] wkup_vec_t;
    typedef logic [`WKUP_GRP_W-1:0] wkup_grp_t;
    typedef logic [1:0] wkup_evt_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } wkup_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } wkup_apb_rsp_t;

endpackage : wkup_pkg

/* wkup_sync.sv */
`timescale 1ns/1ps
`include "wkup_params.svh"
module wkup_sync (
    // Clock and reset
    input logic mclk,
    input logic rstn,
    // Raw inputs
    input wkup_pkg::wkup_vec_t async_in,
    // Synchronised level and edges
    output wkup_pkg::wkup_vec_t level,
    output wkup_pkg::wkup_vec_t rise,
    output wkup_pkg::wkup_vec_t fall
);
    import wkup_pkg::*;

    wkup_vec_t meta_reg;
    wkup_vec_t sync_reg;
    wkup_vec_t prev_reg;

    // First stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= sync_reg;
        end
    end

    logic [2:0] warm_reg;

    // Edges held off until prev_reg carries a real sample, so a pin idling high gives no false edge
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            warm_reg <= 3'h0;
        end else begin
            warm_reg <= {warm_reg[1:0], 1'h1};
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg & ~prev_reg & {`WKUP_CHANNELS{warm_reg[2]}};
    assign fall = ~sync_reg & prev_reg & {`WKUP_CHANNELS{warm_reg[2]}};

endmodule : wkup_sync

/* wkup_unit.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "wkup_params.svh"
module wkup_unit (
    // Clock and reset
    input logic mclk,
    input logic rstn,

    // Register bus
    input wkup_pkg::wkup_apb_req_t apb_req,
    output wkup_pkg::wkup_apb_rsp_t apb_rsp,

    // Wake-up sources, pins and internal modules
    input wkup_pkg::wkup_vec_t wake_in,

    // Towards the interrupt controller
    output wkup_pkg::wkup_vec_t wake_req,
    output logic irq_channel_five,

    // Block interrupt
    output logic irq
);
    import wkup_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    function automatic logic wkup_hit(input logic [15:0] addr);
        logic [3:0] idx;
        logic [15:0] base;
        idx = addr[5:2];
        base = `WKUP_BASE_ADDR;
        wkup_hit = (addr[15:6] == base[15:6]) && (addr[1:0] == 2'h0)
            && (idx <= `WKUP_IDX_EVT_MASK);
    endfunction : wkup_hit

    function automatic logic [3:0] wkup_idx(input logic [15:0] addr);
        wkup_idx = addr[5:2];
    endfunction : wkup_idx

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [`WKUP_GROUPS-1:0][`WKUP_GRP_W-1:0] edge_mode_reg;
    logic [`WKUP_GROUPS-1:0][`WKUP_GRP_W-1:0] edge_sense_reg;
    logic [`WKUP_GROUPS-1:0][`WKUP_GRP_W-1:0] wake_enable_reg;
    wkup_evt_t evt_status_reg;
    wkup_evt_t evt_mask_reg;
    logic [31:0] rdata_reg;
    logic err_reg;
    wkup_vec_t wake_req_reg;
    logic irq_five_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic apb_setup;
    logic apb_access;
    logic apb_hit;
    logic [3:0] apb_idx;
    logic [1:0] apb_grp;
    logic apb_wr;
    logic wr_mode;
    logic wr_sense;
    logic wr_en;

    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign apb_access = apb_req.psel && apb_req.penable;
    assign apb_hit = wkup_hit(apb_req.paddr);
    assign apb_idx = wkup_idx(apb_req.paddr);
    assign apb_grp = apb_idx[1:0];
    assign apb_wr = apb_access && apb_req.pwrite && apb_hit;
    assign wr_mode = apb_wr && (apb_idx <= `WKUP_IDX_MODE4);
    assign wr_sense = apb_wr && (apb_idx >= `WKUP_IDX_SENSE1) && (apb_idx <= `WKUP_IDX_SENSE4);
    assign wr_en = apb_wr && (apb_idx >= `WKUP_IDX_EN1) && (apb_idx <= `WKUP_IDX_EN4);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation and edge detection

    wkup_vec_t in_level;
    wkup_vec_t in_rise;
    wkup_vec_t in_fall;

    // All channels, pin or internal, pass the same synchroniser
    wkup_sync u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .async_in(wake_in),
        .level(in_level),
        .rise(in_rise),
        .fall(in_fall)
    );

    wkup_vec_t mode_vec;
    wkup_vec_t en_vec;
    wkup_vec_t sense_vec;
    wkup_vec_t trig_vec;
    wkup_vec_t set_vec;
    wkup_vec_t clr_vec;

    assign mode_vec = edge_mode_reg;
    assign en_vec = wake_enable_reg;
    assign sense_vec = edge_sense_reg;

    // Per-channel edge choice
    assign trig_vec = (mode_vec & in_fall) | (~mode_vec & in_rise);
    // Only enabled channels latch; others are dropped
    assign set_vec = trig_vec & en_vec;

    always_comb begin
        clr_vec = '0;
        if (wr_sense) begin
            clr_vec[apb_grp*`WKUP_GRP_W +: `WKUP_GRP_W] = apb_req.pwdata[`WKUP_GRP_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge mode registers

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            edge_mode_reg <= {`WKUP_GROUPS{`WKUP_RST_MODE}};
        end else if (wr_mode) begin
            edge_mode_reg[apb_grp] <= apb_req.pwdata[`WKUP_GRP_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake enable registers

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wake_enable_reg <= {`WKUP_GROUPS{`WKUP_RST_EN}};
        end else if (wr_en) begin
            wake_enable_reg[apb_grp] <= apb_req.pwdata[`WKUP_GRP_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge sense latches, set beats clear

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            edge_sense_reg <= {`WKUP_GROUPS{`WKUP_RST_SENSE}};
        end else begin
            edge_sense_reg <= (sense_vec & ~clr_vec) | set_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Requests to the interrupt controller

    wkup_vec_t wake_req_next;

    // Enabled: held by the sense latch; disabled: raw synchronised level
    assign wake_req_next = (en_vec & sense_vec) | (~en_vec & in_level);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wake_req_reg <= '0;
            irq_five_reg <= 1'b0;
        end else begin
            wake_req_reg <= wake_req_next;
            irq_five_reg <= wake_req_next[`WKUP_CH_A] | wake_req_next[`WKUP_CH_D];
        end
    end

    assign wake_req = wake_req_reg;
    assign irq_channel_five = irq_five_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Block event status and mask

    wkup_evt_t evt_set;
    wkup_evt_t evt_clr;

    always_comb begin
        evt_set = '0;
        evt_set[`WKUP_EVT_LATCH] = |(set_vec & ~sense_vec);
        evt_set[`WKUP_EVT_DROP] = |(trig_vec & ~en_vec);
        evt_clr = '0;
        if (apb_wr && (apb_idx == `WKUP_IDX_EVT_STAT)) begin
            evt_clr = apb_req.pwdata[1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            evt_status_reg <= `WKUP_RST_EVT;
        end else begin
            evt_status_reg <= (evt_status_reg & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            evt_mask_reg <= `WKUP_RST_EVT;
        end else if (apb_wr && (apb_idx == `WKUP_IDX_EVT_MASK)) begin
            evt_mask_reg <= apb_req.pwdata[1:0];
        end
    end

    assign irq = |(evt_status_reg & evt_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup phase

    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (apb_idx)
            `WKUP_IDX_MODE1, `WKUP_IDX_MODE2, `WKUP_IDX_MODE3, `WKUP_IDX_MODE4: begin
                rdata_next[`WKUP_GRP_W-1:0] = edge_mode_reg[apb_grp];
            end
            `WKUP_IDX_SENSE1, `WKUP_IDX_SENSE2, `WKUP_IDX_SENSE3, `WKUP_IDX_SENSE4: begin
                rdata_next[`WKUP_GRP_W-1:0] = edge_sense_reg[apb_grp];
            end
            `WKUP_IDX_EN1, `WKUP_IDX_EN2, `WKUP_IDX_EN3, `WKUP_IDX_EN4: begin
                rdata_next[`WKUP_GRP_W-1:0] = wake_enable_reg[apb_grp];
            end
            `WKUP_IDX_EVT_STAT: begin
                rdata_next[1:0] = evt_status_reg;
            end
            `WKUP_IDX_EVT_MASK: begin
                rdata_next[1:0] = evt_mask_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
        if (!apb_hit) begin
            rdata_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (apb_setup) begin
            rdata_reg <= apb_req.pwrite ? 32'h0000_0000 : rdata_next;
            err_reg <= !apb_hit;
        end
    end

    // Zero wait states: pready is always high
    assign apb_rsp = {rdata_reg, 1'h1, apb_access && err_reg};

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_sense_latch: assert property (
        @(posedge mclk) disable iff (!rstn)
        (set_vec != '0) |=> ((sense_vec & $past(set_vec)) == $past(set_vec))
    ) else $error("enabled trigger did not latch its sense bit");

    a_sense_drop: assert property (
        @(posedge mclk) disable iff (!rstn)
        1'b1 |=> ((sense_vec & ~$past(sense_vec) & ~$past(en_vec)) == '0)
    ) else $error("disabled channel latched a sense bit");

    a_sense_hw_only: assert property (
        @(posedge mclk) disable iff (!rstn)
        1'b1 |=> ((sense_vec & ~$past(sense_vec) & ~$past(trig_vec)) == '0)
    ) else $error("sense bit set without a trigger");

    a_sense_clear: assert property (
        @(posedge mclk) disable iff (!rstn)
        wr_sense |=> ((sense_vec & $past(clr_vec) & ~$past(set_vec)) == '0)
    ) else $error("write of one did not clear sense bit");

    a_sense_keep: assert property (
        @(posedge mclk) disable iff (!rstn)
        1'b1 |=> ((~sense_vec & $past(sense_vec) & ~$past(clr_vec)) == '0)
    ) else $error("sense bit lost without a clear");

    a_fall_select: assert property (
        @(posedge mclk) disable iff (!rstn)
        ((in_fall & mode_vec & en_vec) != '0)
            |=> ((sense_vec & $past(in_fall & mode_vec & en_vec)) == $past(in_fall & mode_vec & en_vec))
    ) else $error("falling edge in falling mode not latched");

    a_wake_route: assert property (
        @(posedge mclk) disable iff (!rstn)
        1'b1 |=> (wake_req == $past((en_vec & sense_vec) | (~en_vec & in_level)))
    ) else $error("wake request routing wrong");

    a_wake_hold: assert property (
        @(posedge mclk) disable iff (!rstn)
        ((en_vec & sense_vec) != '0) |=> ((wake_req & $past(en_vec & sense_vec)) == $past(en_vec & sense_vec))
    ) else $error("enabled request dropped while sense set");

    a_chan_five: assert property (
        @(posedge mclk) disable iff (!rstn)
        irq_channel_five == (wake_req[`WKUP_CH_A] | wake_req[`WKUP_CH_D])
    ) else $error("channel five is not A or D");

    a_mode_write: assert property (
        @(posedge mclk) disable iff (!rstn)
        wr_mode |=> (edge_mode_reg[$past(apb_grp)] == $past(apb_req.pwdata[7:0]))
    ) else $error("edge mode write lost");

    a_enable_write: assert property (
        @(posedge mclk) disable iff (!rstn)
        wr_en |=> (wake_enable_reg[$past(apb_grp)] == $past(apb_req.pwdata[7:0]))
    ) else $error("wake enable write lost");

    a_sense_read: assert property (
        @(posedge mclk) disable iff (!rstn)
        (apb_setup && !apb_req.pwrite && apb_hit && (apb_idx >= `WKUP_IDX_SENSE1)
            && (apb_idx <= `WKUP_IDX_SENSE4))
            |=> (rdata_reg == {24'h00_0000, $past(edge_sense_reg[apb_grp])})
    ) else $error("sense read data wrong");

    a_reset_clear: assert property (
        @(posedge mclk)
        !rstn |=> ((sense_vec == '0) && (mode_vec == '0) && (wake_req == '0))
    ) else $error("state not cleared by reset");

    a_one_wake: assert property (
        @(posedge mclk) disable iff (!rstn)
        (set_vec != '0) |=> ##1 ((wake_req & $past(set_vec, 2)) == $past(set_vec, 2))
    ) else $error("enabled trigger gave no wake request");

    a_rise_select: assert property (
        @(posedge mclk) disable iff (!rstn)
        ((in_rise & ~mode_vec & en_vec) != '0)
            |=> ((sense_vec & $past(in_rise & ~mode_vec & en_vec)) == $past(in_rise & ~mode_vec & en_vec))
    ) else $error("rising edge in rising mode not latched");

    a_bypass_level: assert property (
        @(posedge mclk) disable iff (!rstn)
        1'b1 |=> ((wake_req & ~$past(en_vec) & ~$past(in_level)) == '0)
    ) else $error("disabled channel request without input level");

    a_evt_set_wins: assert property (
        @(posedge mclk) disable iff (!rstn)
        (evt_set != '0) |=> ((evt_status_reg & $past(evt_set)) == $past(evt_set))
    ) else $error("event status bit not set");

    a_unmapped_err: assert property (
        @(posedge mclk) disable iff (!rstn)
        (apb_setup && !apb_hit) |=> apb_rsp.pslverr
    ) else $error("unmapped access gave no error");

    a_mapped_no_err: assert property (
        @(posedge mclk) disable iff (!rstn)
        (apb_setup && apb_hit) |=> !apb_rsp.pslverr
    ) else $error("mapped access gave an error");

endmodule : wkup_unit

/* wkup_interrupt_controller_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Interrupt controller side: high-level triggered capture of wake requests
module wkup_interrupt_controller_model (
    // Clock and reset
    input logic mclk,
    input logic rstn,
    // From the wake-up unit
    input wkup_pkg::wkup_vec_t wake_req,
    input logic irq_channel_five,
    // Captured requests
    output wkup_pkg::wkup_vec_t seen,
    output logic ch5_seen
);
    import wkup_pkg::*;

    wkup_vec_t seen_reg;
    logic ch5_reg;

    // Level triggered: any high request cycle is remembered until reset
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            seen_reg <= '0;
            ch5_reg <= 1'h0;
        end else begin
            seen_reg <= seen_reg | wake_req;
            ch5_reg <= ch5_reg | irq_channel_five;
        end
    end

    assign seen = seen_reg;
    assign ch5_seen = ch5_reg;
endmodule : wkup_interrupt_controller_model

/* testbench.sv */
`timescale 1ns/1ps
`include "wkup_params.svh"
module testbench;
    import wkup_pkg::*;

    logic mclk;
    logic rstn;
    wkup_apb_req_t apb_req;
    wkup_apb_rsp_t apb_rsp;
    wkup_vec_t wake_in;
    wkup_vec_t wake_req;
    wkup_vec_t seen;
    logic irq_channel_five;
    logic irq;
    logic ch5_seen;
    int num_errors = 0;
    int check_count = 0;

    ////////////////////////////////////////////////////////////////////////////
    wkup_unit wkup_unit_inst (
        .mclk(mclk),
        .rstn(rstn),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .wake_in(wake_in),
        .wake_req(wake_req),
        .irq_channel_five(irq_channel_five),
        .irq(irq)
    );

    wkup_interrupt_controller_model wkup_interrupt_controller_model_inst (
        .mclk(mclk),
        .rstn(rstn),
        .wake_req(wake_req),
        .irq_channel_five(irq_channel_five),
        .seen(seen),
        .ch5_seen(ch5_seen)
    );

    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
        check_count++;
        if (seen_v !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen_v);
        end
    endtask : check

    // One APB transfer; entered just after a rising edge, leaves one edge after release
    task automatic apb_xfer(input logic wr_en, input logic [15:0] addr, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        apb_req.psel <= 1'h1;
        apb_req.penable <= 1'h0;
        apb_req.pwrite <= wr_en;
        apb_req.paddr <= addr;
        apb_req.pwdata <= wd;
        @(posedge mclk);
        apb_req.penable <= 1'h1;
        @(posedge mclk);
        while (apb_rsp.pready !== 1'h1 && n < 20) begin
            n++;
            @(posedge mclk);
        end
        if (n >= 20) begin
            num_errors++;
            finish_test();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'h0;
        apb_req.penable <= 1'h0;
        @(posedge mclk);
    endtask : apb_xfer

    function automatic logic [15:0] reg_addr(input logic [3:0] idx);
        return `WKUP_BASE_ADDR + {10'h000, idx, 2'h0};
    endfunction : reg_addr

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb_xfer(1'h1, reg_addr(idx), {24'h000000, d}, r, e);
    endtask : wr

    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp, input string name);
        logic [31:0] r;
        logic e;
        apb_xfer(1'h0, reg_addr(idx), 32'h00000000, r, e);
        check(name, r, {24'h000000, exp});
        check({name, " slverr"}, {31'h00000000, e}, 32'h00000000);
    endtask : rd_chk

    // Bounded wait for one request line to reach a level
    task automatic wait_req(input int ch, input logic v, input string name);
        int n;
        n = 0;
        while (wake_req[ch] !== v && n < 12) begin
            n++;
            @(posedge mclk);
        end
        if (n >= 12) begin
            num_errors++;
            finish_test();
        end
        check(name, {31'h00000000, wake_req[ch]}, {31'h00000000, v});
    endtask : wait_req

    task automatic irq_chk(input logic exp);
        check("irq", {31'h00000000, irq}, {31'h00000000, exp});
    endtask : irq_chk

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic e;
        mclk = 1'h0;
        rstn = 1'h0;
        apb_req = '0;
        wake_in = '0;
        repeat (5) @(posedge mclk);
        rstn <= 1'h1;
        @(posedge mclk);
        // Reset values of every register
        for (int i = 0; i < 14; i++) rd_chk(i[3:0], 8'h00, "reset value");
        // Mode and enable registers read back; sense cannot be set by writes
        for (int i = 0; i < 12; i++) if (i < 4 || i > 7) wr(i[3:0], 8'hA5 ^ i[7:0]);
        for (int i = 0; i < 12; i++) if (i < 4 || i > 7) rd_chk(i[3:0], 8'hA5 ^ i[7:0], "rw reg");
        for (int i = 4; i < 8; i++) wr(i[3:0], 8'hFF);
        for (int i = 4; i < 8; i++) rd_chk(i[3:0], 8'h00, "sense sw set");
        for (int i = 0; i < 12; i++) wr(i[3:0], 8'h00);
        // Unmapped index and misaligned address
        apb_xfer(1'h0, reg_addr(4'hE), 32'h00000000, r, e);
        check("unmapped rd", r, 32'h00000000);
        check("unmapped err", {31'h00000000, e}, 32'h00000001);
        apb_xfer(1'h1, reg_addr(4'h0) + 16'h0001, 32'h000000FF, r, e);
        check("misaligned err", {31'h00000000, e}, 32'h00000001);
        rd_chk(`WKUP_IDX_MODE1, 8'h00, "mode1 untouched");
        // Enabled rising channel A latches and holds
        wr(`WKUP_IDX_EN1, 8'h01);
        wake_in[0] <= 1'h1;
        wait_req(0, 1'h1, "req ch0 set");
        rd_chk(`WKUP_IDX_SENSE1, 8'h01, "sense1 ch0");
        check("ch5 from A", {31'h00000000, irq_channel_five}, 32'h00000001);
        wake_in[0] <= 1'h0;
        repeat (6) @(posedge mclk);
        check("req ch0 held", {31'h00000000, wake_req[0]}, 32'h00000001);
        wr(`WKUP_IDX_SENSE1, 8'h00);
        rd_chk(`WKUP_IDX_SENSE1, 8'h01, "sense w0");
        wr(`WKUP_IDX_SENSE1, 8'h01);
        wait_req(0, 1'h0, "req ch0 cleared");
        check("interrupt_controller saw ch0", {31'h00000000, seen[0]}, 32'h00000001);
        // Falling mode on channel 9: rising edge ignored, falling edge latched
        wr(`WKUP_IDX_MODE2, 8'h02);
        wr(`WKUP_IDX_EN2, 8'h02);
        wake_in[9] <= 1'h1;
        repeat (6) @(posedge mclk);
        rd_chk(`WKUP_IDX_SENSE2, 8'h00, "sense2 on rise");
        wake_in[9] <= 1'h0;
        wait_req(9, 1'h1, "req ch9 fall");
        rd_chk(`WKUP_IDX_SENSE2, 8'h02, "sense2 on fall");
        // Disabled channel D bypasses the latch
        wake_in[3] <= 1'h1;
        wait_req(3, 1'h1, "bypass ch3 high");
        check("ch5 from D", {31'h00000000, irq_channel_five}, 32'h00000001);
        rd_chk(`WKUP_IDX_SENSE1, 8'h00, "no pending ch3");
        wake_in[3] <= 1'h0;
        wait_req(3, 1'h0, "bypass ch3 low");
        check("interrupt_controller ch5", {31'h00000000, ch5_seen}, 32'h00000001);
        // Block interrupt: status, mask, clear
        rd_chk(`WKUP_IDX_EVT_STAT, 8'h03, "evt status");
        irq_chk(1'h0);
        wr(`WKUP_IDX_EVT_MASK, 8'h02);
        irq_chk(1'h1);
        wr(`WKUP_IDX_EVT_STAT, 8'h02);
        irq_chk(1'h0);
        rd_chk(`WKUP_IDX_EVT_STAT, 8'h01, "evt after clr");
        wr(`WKUP_IDX_EVT_MASK, 8'h01);
        irq_chk(1'h1);
        wr(`WKUP_IDX_EVT_STAT, 8'h01);
        irq_chk(1'h0);
        // Reset in mid-run drops a latched request; an input high across reset gives no false edge
        wake_in[0] <= 1'h1;
        wait_req(0, 1'h1, "req ch0 again");
        rstn <= 1'h0;
        wake_in[0] <= 1'h0;
        wake_in[5] <= 1'h1;
        repeat (3) @(posedge mclk);
        rstn <= 1'h1;
        @(posedge mclk);
        check("req after rst", wake_req, 32'h00000000);
        rd_chk(`WKUP_IDX_SENSE1, 8'h00, "sense after rst");
        repeat (4) @(posedge mclk);
        check("bypass ch5 after rst", {31'h00000000, wake_req[5]}, 32'h00000001);
        rd_chk(`WKUP_IDX_EVT_STAT, 8'h00, "no edge after rst");
        finish_test();
    end
endmodule : testbench
